//--- pfs_params.svh
// Timing constants for the power-fail sequencer
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

`define PFS_CLK_NS 100
`define PFS_PF_TIMEOUT_NS 5000000
`define PFS_SUP_HOLD_NS 3000000
`define PFS_LINE_HOLD_NS 70000000
`define PFS_FILT_NS 100
`define PFS_INIT_MIN_NS 1000
`define PFS_CLK_RUN_NS 2000
// Least times round up to whole cycles
`define PFS_PF_TIMEOUT_CYC ((`PFS_PF_TIMEOUT_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)
`define PFS_SUP_HOLD_CYC ((`PFS_SUP_HOLD_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)
`define PFS_LINE_HOLD_CYC ((`PFS_LINE_HOLD_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)
`define PFS_FILT_CYC ((`PFS_FILT_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)
`define PFS_INIT_MIN_CYC ((`PFS_INIT_MIN_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)
`define PFS_CLK_RUN_CYC ((`PFS_CLK_RUN_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)
`define PFS_NUM_SUPPLIES 3
`define PFS_NUM_RX 3
`define PFS_CNT_W 20

`endif

//--- pfs_pkg.sv
// Types for the power-fail sequencer
`include "pfs_params.svh"
package pfs_pkg;
    typedef enum logic [2:0] {
        PFS_IDLE,
        PFS_LINE_LOW,
        PFS_SUPPLY_LOW,
        PFS_SUP_HOLD,
        PFS_LINE_HOLD
    } pfs_state_e;

    // Pin levels, high means the condition is asserted
    typedef struct packed {
        logic [`PFS_NUM_SUPPLIES-1:0] line_power_low;
        logic [`PFS_NUM_SUPPLIES-1:0] supply_power_low;
        logic clk_supply_low;
        logic [`PFS_NUM_RX-1:0] rx_low;
        logic console_reset;
        logic maint;
    } pfs_pins_s;

    // Wired-OR drive enables, high pulls the line to its asserted level
    typedef struct packed {
        logic restart_hold;
        logic power_loss_reset;
        logic console_bus_power_ok;
        logic console_bus_supply_ok;
        logic internal_line_low;
        logic internal_supply_low;
    } pfs_drive_s;
endpackage

//--- pfs_sequencer.sv
// Power-fail sequencer: line-low and supply-low sequencing with init outputs
//
// Operation
// - Start on rising edge of combined line-low
// - Combined line-low sets interrupt, feeds branch bit
// - Interrupt starts power-fail timeout, forces line-low
// - Timeout end raises synthetic supply-low
// - Supply-low forces supply-low flop and both inits
// - Supply-low release starts 3 ms, then clears
// - Then 70 ms timeout clears forced line-low
// - Retrigger only after forced line-low clears
// - Return to idle unless supply-low stays
// - Console reset forces inits only
// - Maintenance input cycles fail and return repeatedly
// - Filter short releases of received signals
// - Receive power-loss reset, restart-hold, console line-low
// - Drive outputs through wired-OR enables
// - Restart-hold released only after all release
// - Power-loss reset follows clock supply-low
// - Release power-loss reset after 2 us clock
// - Line-low held at least 5 ms
// - Supply-low held at least 1 us
`timescale 1ns/1ns
`include "pfs_params.svh"
module pfs_sequencer
#(
    parameter int PF_TIMEOUT_CYC = `PFS_PF_TIMEOUT_CYC,
    parameter int SUP_HOLD_CYC = `PFS_SUP_HOLD_CYC,
    parameter int LINE_HOLD_CYC = `PFS_LINE_HOLD_CYC
)
(
    input wire logic SYS_CLK, // 10 MHz processor clock
    input wire logic NRST, // Synchronous reset, active low
    input wire logic [`PFS_NUM_SUPPLIES-1:0] LINE_POWER_LOW_N, // Supply line-low pins
    input wire logic [`PFS_NUM_SUPPLIES-1:0] SUPPLY_POWER_LOW_N, // Supply supply-low pins
    input wire logic CLK_SUPPLY_LOW_N, // Clock/terminator supply-low
    input wire logic RESTART_HOLD_N_I, // Backplane restart-hold received
    input wire logic POWER_LOSS_RESET_N_I, // Backplane power-loss reset received
    input wire logic CONSOLE_LINE_LOW_N_I, // Buffered console-bus line-low
    input wire logic CONSOLE_RESET_N, // Console reset
    input wire logic MAINT_N, // Maintenance cycling strap
    input wire logic PF_INT_CLR, // Interrupt acknowledge pulse
    output logic PF_INT, // Power-fail interrupt
    output logic BRANCH_TEST_BIT, // Combined line-low for microcode
    output logic SYSTEM_INIT, // System initialize
    output logic MICROCODE_INITIALIZE, // Microcode initialize
    output logic DRIVE_LEVEL, // Level on every driven line, always low
    output pfs_pkg::pfs_drive_s DRIVE_OE // Wired-OR output enables
);
    import pfs_pkg::*;

    localparam int RX_PLR = 0;
    localparam int RX_HOLD = 1;
    localparam int RX_CONS = 2;
    localparam logic [`PFS_CNT_W-1:0] FILT_LAST = `PFS_CNT_W'(`PFS_FILT_CYC);
    localparam logic [`PFS_CNT_W-1:0] INIT_LAST = `PFS_CNT_W'(`PFS_INIT_MIN_CYC - 1);
    localparam logic [`PFS_CNT_W-1:0] RUN_LAST = `PFS_CNT_W'(`PFS_CLK_RUN_CYC - 1);

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    pfs_pins_s pins_raw;
    pfs_pins_s meta_ff;
    pfs_pins_s sync_ff;
    pfs_pins_s nxt_meta;
    pfs_pins_s nxt_sync;

    always_comb
    begin
        pins_raw.line_power_low = ~LINE_POWER_LOW_N;
        pins_raw.supply_power_low = ~SUPPLY_POWER_LOW_N;
        pins_raw.clk_supply_low = ~CLK_SUPPLY_LOW_N;
        pins_raw.rx_low = {~CONSOLE_LINE_LOW_N_I, ~RESTART_HOLD_N_I, ~POWER_LOSS_RESET_N_I};
        pins_raw.console_reset = ~CONSOLE_RESET_N;
        pins_raw.maint = ~MAINT_N;
        nxt_meta = pins_raw;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    // --------------------------------------------------------------
    // Release filters on received lines
    // --------------------------------------------------------------
    // Asserting edges pass at once; a release must hold past a bus transient
    logic [`PFS_NUM_RX-1:0] rx_filt;

    genvar gi;
    generate
        for (gi = 0; gi < `PFS_NUM_RX; gi++)
        begin : g_filt
            logic [`PFS_CNT_W-1:0] rel_cnt_ff;
            logic [`PFS_CNT_W-1:0] nxt_rel_cnt;
            logic held_ff;
            logic nxt_held;

            always_comb
            begin
                nxt_rel_cnt = '0;
                nxt_held = held_ff;
                if (sync_ff.rx_low[gi])
                begin
                    nxt_held = 1'b1;
                end
                else if (held_ff)
                begin
                    nxt_rel_cnt = rel_cnt_ff + `PFS_CNT_W'(1);
                    if (rel_cnt_ff == FILT_LAST)
                    begin
                        nxt_held = 1'b0;
                        nxt_rel_cnt = '0;
                    end
                end
            end

            always_ff @(posedge SYS_CLK)
            begin
                if (!NRST)
                begin
                    rel_cnt_ff <= '0;
                    held_ff <= 1'b0;
                end
                else
                begin
                    rel_cnt_ff <= nxt_rel_cnt;
                    held_ff <= nxt_held;
                end
            end

            assign rx_filt[gi] = held_ff;
        end
    endgenerate

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    pfs_state_e state_ff;
    pfs_state_e nxt_state;
    logic [`PFS_CNT_W-1:0] cnt_ff;
    logic [`PFS_CNT_W-1:0] nxt_cnt;
    logic comb_line_ff;
    logic nxt_comb_line;
    logic synth_ff;
    logic nxt_synth;
    logic pf_int_ff;
    logic nxt_pf_int;
    logic fline_ff;
    logic nxt_fline;
    logic fsup_ff;
    logic nxt_fsup;
    logic maint_req;
    logic combined_line_low;
    logic line_rise;
    logic sup_or;

    // Maintenance fakes a line-low each time the sequencer is idle
    assign maint_req = sync_ff.maint && state_ff == PFS_IDLE;
    assign combined_line_low = (|sync_ff.line_power_low) || rx_filt[RX_HOLD]
        || rx_filt[RX_CONS] || maint_req;
    assign line_rise = combined_line_low && !comb_line_ff;
    assign sup_or = synth_ff || (|sync_ff.supply_power_low) || rx_filt[RX_PLR];

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + `PFS_CNT_W'(1);
        nxt_comb_line = combined_line_low;
        nxt_synth = synth_ff;
        nxt_pf_int = pf_int_ff;
        if (PF_INT_CLR)
        begin
            nxt_pf_int = 1'b0;
        end
        case (state_ff)
            PFS_IDLE:
            begin
                nxt_cnt = '0;
                if (sup_or)
                begin
                    nxt_state = PFS_SUPPLY_LOW;
                end
                else if (line_rise)
                begin
                    nxt_pf_int = 1'b1;
                    nxt_state = PFS_LINE_LOW;
                end
            end
            PFS_LINE_LOW:
            begin
                // Timeout length keeps line-low up for the full window
                if (cnt_ff == `PFS_CNT_W'(PF_TIMEOUT_CYC - 1))
                begin
                    nxt_synth = 1'b1;
                    nxt_cnt = '0;
                    nxt_state = PFS_SUPPLY_LOW;
                end
                else if (sup_or)
                begin
                    nxt_cnt = '0;
                    nxt_state = PFS_SUPPLY_LOW;
                end
            end
            PFS_SUPPLY_LOW:
            begin
                if (synth_ff && cnt_ff == INIT_LAST)
                begin
                    nxt_synth = 1'b0;
                end
                if (!sup_or)
                begin
                    nxt_cnt = '0;
                    nxt_state = PFS_SUP_HOLD;
                end
            end
            PFS_SUP_HOLD:
            begin
                if (sup_or)
                begin
                    nxt_cnt = '0;
                    nxt_state = PFS_SUPPLY_LOW;
                end
                else if (cnt_ff == `PFS_CNT_W'(SUP_HOLD_CYC - 1))
                begin
                    nxt_cnt = '0;
                    nxt_state = PFS_LINE_HOLD;
                end
            end
            PFS_LINE_HOLD:
            begin
                if (sup_or)
                begin
                    nxt_cnt = '0;
                    nxt_state = PFS_SUPPLY_LOW;
                end
                else if (cnt_ff == `PFS_CNT_W'(LINE_HOLD_CYC - 1))
                begin
                    nxt_cnt = '0;
                    nxt_state = PFS_IDLE;
                end
            end
            default:
            begin
                nxt_cnt = '0;
                nxt_state = PFS_IDLE;
            end
        endcase
        nxt_fline = nxt_state != PFS_IDLE;
        nxt_fsup = nxt_state == PFS_SUPPLY_LOW || nxt_state == PFS_SUP_HOLD;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            state_ff <= PFS_IDLE;
            cnt_ff <= '0;
            comb_line_ff <= 1'b0;
            synth_ff <= 1'b0;
            pf_int_ff <= 1'b0;
            fline_ff <= 1'b0;
            fsup_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            comb_line_ff <= nxt_comb_line;
            synth_ff <= nxt_synth;
            pf_int_ff <= nxt_pf_int;
            fline_ff <= nxt_fline;
            fsup_ff <= nxt_fsup;
        end
    end

    // --------------------------------------------------------------
    // Power-loss reset and outputs
    // --------------------------------------------------------------
    logic plr_ff;
    logic nxt_plr;
    logic [`PFS_CNT_W-1:0] run_cnt_ff;
    logic [`PFS_CNT_W-1:0] nxt_run_cnt;
    logic init_ff;
    logic nxt_init;
    logic uinit_ff;
    logic nxt_uinit;
    logic branch_ff;
    logic nxt_branch;
    pfs_drive_s oe_ff;
    pfs_drive_s nxt_oe;

    always_comb
    begin
        nxt_plr = plr_ff;
        nxt_run_cnt = '0;
        if (sync_ff.clk_supply_low)
        begin
            nxt_plr = 1'b1;
        end
        else if (plr_ff)
        begin
            // Clock must run a while before devices leave reset
            nxt_run_cnt = run_cnt_ff + `PFS_CNT_W'(1);
            if (run_cnt_ff == RUN_LAST)
            begin
                nxt_plr = 1'b0;
                nxt_run_cnt = '0;
            end
        end
        nxt_init = nxt_fsup || sync_ff.console_reset;
        nxt_uinit = nxt_fsup || sync_ff.console_reset;
        nxt_branch = combined_line_low;
        nxt_oe.restart_hold = nxt_fline;
        nxt_oe.power_loss_reset = nxt_plr;
        nxt_oe.console_bus_power_ok = nxt_fline;
        nxt_oe.console_bus_supply_ok = nxt_fsup;
        nxt_oe.internal_line_low = nxt_fline;
        nxt_oe.internal_supply_low = nxt_fsup;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            plr_ff <= 1'b0;
            run_cnt_ff <= '0;
            init_ff <= 1'b0;
            uinit_ff <= 1'b0;
            branch_ff <= 1'b0;
            oe_ff <= '0;
        end
        else
        begin
            plr_ff <= nxt_plr;
            run_cnt_ff <= nxt_run_cnt;
            init_ff <= nxt_init;
            uinit_ff <= nxt_uinit;
            branch_ff <= nxt_branch;
            oe_ff <= nxt_oe;
        end
    end

    logic zero_ff;
    always_ff @(posedge SYS_CLK)
    begin
        zero_ff <= 1'b0;
    end

    assign PF_INT = pf_int_ff;
    assign BRANCH_TEST_BIT = branch_ff;
    assign SYSTEM_INIT = init_ff;
    assign MICROCODE_INITIALIZE = uinit_ff;
    assign DRIVE_LEVEL = zero_ff;
    assign DRIVE_OE = oe_ff;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    sequence seq_trigger;
        state_ff == PFS_IDLE && !sup_or && line_rise;
    endsequence

    chk_trigger_sets_int: assert property (seq_trigger |=> pf_int_ff)
        else $error("interrupt not set on line-low edge");
    chk_trigger_forces_line: assert property (seq_trigger |=> fline_ff ##0 oe_ff.internal_line_low [*2])
        else $error("forced line-low not set after trigger");
    chk_timeout_synthetic: assert property (state_ff == PFS_LINE_LOW
        && cnt_ff == `PFS_CNT_W'(PF_TIMEOUT_CYC - 1) |=> synth_ff && fsup_ff)
        else $error("synthetic supply-low missing at timeout");
    chk_supply_inits: assert property (sup_or && state_ff != PFS_IDLE |=> ##1 init_ff && uinit_ff)
        else $error("inits not asserted during supply-low");
    chk_sup_hold_end: assert property (state_ff == PFS_SUP_HOLD && !sup_or
        && cnt_ff == `PFS_CNT_W'(SUP_HOLD_CYC - 1) |=> !fsup_ff && fline_ff)
        else $error("forced supply-low not cleared after hold");
    chk_line_hold_end: assert property (state_ff == PFS_LINE_HOLD && !sup_or
        && cnt_ff == `PFS_CNT_W'(LINE_HOLD_CYC - 1) |=> !fline_ff && state_ff == PFS_IDLE)
        else $error("forced line-low not cleared after hold");
    chk_no_retrigger: assert property ($rose(pf_int_ff) |-> $past(state_ff) == PFS_IDLE)
        else $error("retrigger while forced line-low set");
    chk_console_reset: assert property ($rose(sync_ff.console_reset) |=> init_ff && uinit_ff
        && $stable(state_ff))
        else $error("console reset did not force inits");
    chk_uinit_min: assert property ($rose(synth_ff) |=> uinit_ff [*8])
        else $error("microcode init shorter than minimum");
    chk_plr_assert: assert property (sync_ff.clk_supply_low |=> ##1 oe_ff.power_loss_reset)
        else $error("power-loss reset not driven");
    chk_plr_release: assert property ($fell(oe_ff.power_loss_reset) |->
        $past(!sync_ff.clk_supply_low, 8) && $past(!sync_ff.clk_supply_low, 2))
        else $error("power-loss reset released too early");
    chk_filter_hold: assert property ($fell(sync_ff.rx_low[RX_HOLD]) |=> rx_filt[RX_HOLD])
        else $error("release passed without filtering");
endmodule

//--- pfs_supply_model.sv
// Partner model: power supplies and backplane nodes facing the sequencer
`timescale 1ns/1ns
module pfs_supply_model
import pfs_pkg::*;
(
    input wire logic clk, // Processor clock
    input pfs_pkg::pfs_pins_s cmd, // Conditions to present, high asserted
    input wire logic glitch, // One-cycle release on console line-low
    input pfs_pkg::pfs_drive_s oe, // Sequencer drive enables
    output logic [2:0] line_n, // Supply line-low pins
    output logic [2:0] supply_n, // Supply supply-low pins
    output logic clk_low_n, // Clock supply-low pin
    output logic hold_n, // Restart-hold line
    output logic plr_n, // Power-loss reset line
    output logic con_n, // Console-bus line-low
    output logic crst_n, // Console reset
    output logic maint_n // Maintenance strap
);
    // ----------------------------------------
    // Pins change only after an edge; released lines float to the pull-up
    // ----------------------------------------
    logic plr_seen;
    // Bit order follows the pin struct: 0 power-loss reset, 1 restart-hold, 2 console
    assign plr_seen = oe.power_loss_reset | cmd.rx_low[0];
    always_ff @(posedge clk)
    begin
        line_n <= ~cmd.line_power_low;
        supply_n <= ~cmd.supply_power_low;
        clk_low_n <= ~cmd.clk_supply_low;
        hold_n <= ~(cmd.rx_low[1] & ~plr_seen);
        plr_n <= ~cmd.rx_low[0];
        con_n <= ~(cmd.rx_low[2] & ~glitch);
        crst_n <= ~cmd.console_reset;
        maint_n <= ~cmd.maint;
    end
endmodule

//--- testbench.sv
// Self-checking bench for the power-fail sequencer
`timescale 1ns/1ns
module testbench;
    import pfs_pkg::*;
    localparam int PF = 20;
    localparam int SUP = 15;
    localparam int LINE = 30;
    localparam int SEQ = PF + SUP + LINE + 80;
    logic SYS_CLK = 0;
    logic NRST = 0;
    logic PF_INT_CLR = 0;
    logic glitch = 0;
    pfs_pins_s cmd = '0;
    logic [2:0] line_n, supply_n;
    logic clk_low_n, hold_n, plr_n, con_n, crst_n, maint_n;
    logic PF_INT, BRANCH_TEST_BIT, SYSTEM_INIT, MICROCODE_INITIALIZE, DRIVE_LEVEL;
    pfs_drive_s DRIVE_OE;
    int fails = 0;
    int n_compared = 0;
    int n, k;
    logic [31:0] exp_q[$];
    string seen_name;
    logic [31:0] seen_val;
    event ev_seen;

    always #50 SYS_CLK = ~SYS_CLK;

    pfs_supply_model u_model (.clk(SYS_CLK), .cmd(cmd), .glitch(glitch), .oe(DRIVE_OE),
        .line_n(line_n), .supply_n(supply_n), .clk_low_n(clk_low_n), .hold_n(hold_n),
        .plr_n(plr_n), .con_n(con_n), .crst_n(crst_n), .maint_n(maint_n));

    pfs_sequencer #(.PF_TIMEOUT_CYC(PF), .SUP_HOLD_CYC(SUP), .LINE_HOLD_CYC(LINE)) u_dut (
        .SYS_CLK(SYS_CLK), .NRST(NRST), .LINE_POWER_LOW_N(line_n),
        .SUPPLY_POWER_LOW_N(supply_n), .CLK_SUPPLY_LOW_N(clk_low_n),
        .RESTART_HOLD_N_I(hold_n), .POWER_LOSS_RESET_N_I(plr_n),
        .CONSOLE_LINE_LOW_N_I(con_n), .CONSOLE_RESET_N(crst_n), .MAINT_N(maint_n),
        .PF_INT_CLR(PF_INT_CLR), .PF_INT(PF_INT), .BRANCH_TEST_BIT(BRANCH_TEST_BIT),
        .SYSTEM_INIT(SYSTEM_INIT), .MICROCODE_INITIALIZE(MICROCODE_INITIALIZE),
        .DRIVE_LEVEL(DRIVE_LEVEL), .DRIVE_OE(DRIVE_OE));

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
            fails++;
        end
    endtask

    // Driver notes the expectation, the watcher pairs it with what was seen
    task automatic note(input string what, input logic [31:0] seen, input logic [31:0] exp);
        exp_q.push_back(exp);
        seen_name = what;
        seen_val = seen;
        -> ev_seen;
        #1;
    endtask

    always @(ev_seen)
    begin
        check(seen_name, seen_val, exp_q.pop_front());
    end

    function automatic logic sig(input int sel);
        case (sel)
            0: sig = PF_INT;
            1: sig = SYSTEM_INIT;
            2: sig = DRIVE_OE.internal_line_low;
            default: sig = DRIVE_OE.power_loss_reset;
        endcase
    endfunction

    // Bounded wait on a settled output, counts cycles taken
    task automatic wait_sig(input int sel, input logic lvl, input int limit, output int cyc);
        cyc = 0;
        while (sig(sel) !== lvl)
        begin
            @(negedge SYS_CLK);
            cyc++;
            if (cyc > limit)
            begin
                $display("wrong value wait %0d expected %0h seen timeout", sel, lvl);
                fails++;
                end_of_test();
            end
        end
    endtask

    task automatic clear_int;
        @(posedge SYS_CLK) PF_INT_CLR <= 1'b1;
        @(posedge SYS_CLK) PF_INT_CLR <= 1'b0;
    endtask

    function automatic logic in_rng(input int v, input int lo, input int hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(99));
        repeat (2) @(posedge SYS_CLK);
        NRST <= 1'b1;
        @(negedge SYS_CLK);
        note("reset outputs", {PF_INT, SYSTEM_INIT, DRIVE_OE}, '0);

        // Full power-fail sequence from one supply
        k = $urandom % 3;
        @(posedge SYS_CLK) cmd.line_power_low[k] <= 1'b1;
        wait_sig(0, 1'b1, 8, n);
        note("pf latency", in_rng(n, 2, 6), 1);
        note("branch bit", BRANCH_TEST_BIT, 1);
        note("line oe", DRIVE_OE.internal_line_low, 1);
        wait_sig(1, 1'b1, PF + 20, n);
        note("timeout len", in_rng(n, PF - 2, PF + 4), 1);
        note("ucode init", MICROCODE_INITIALIZE, 1);
        note("supply oe", DRIVE_OE.internal_supply_low, 1);
        @(posedge SYS_CLK) cmd.line_power_low[k] <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
        cmd.line_power_low[k] <= 1'b1;
        clear_int();
        wait_sig(1, 1'b0, SUP + 40, n);
        note("init len", in_rng(n, SUP + 3, SUP + 8), 1);
        wait_sig(2, 1'b0, LINE + 20, n);
        note("line hold", in_rng(n, LINE - 2, LINE + 4), 1);
        repeat (40) @(posedge SYS_CLK);
        note("no retrigger", PF_INT, 0);
        cmd.line_power_low[k] <= 1'b0;
        $display("test sequence done");

        // Supply-low without line-low, held then released
        @(posedge SYS_CLK) cmd.supply_power_low[k] <= 1'b1;
        wait_sig(1, 1'b1, 8, n);
        note("supply no int", {PF_INT, MICROCODE_INITIALIZE}, 2'b01);
        repeat (50) @(posedge SYS_CLK);
        note("held init", SYSTEM_INIT, 1);
        cmd.supply_power_low[k] <= 1'b0;
        wait_sig(1, 1'b0, SUP + 20, n);
        note("release hold", in_rng(n, SUP, SUP + 6), 1);
        repeat (LINE + 20) @(posedge SYS_CLK);
        note("back idle", {SYSTEM_INIT, DRIVE_OE}, '0);
        $display("test supply done");

        // Console reset touches only the inits
        @(posedge SYS_CLK) cmd.console_reset <= 1'b1;
        wait_sig(1, 1'b1, 6, n);
        note("console state", {PF_INT, MICROCODE_INITIALIZE, DRIVE_OE}, 8'h40);
        @(posedge SYS_CLK) cmd.console_reset <= 1'b0;
        wait_sig(1, 1'b0, 6, n);
        $display("test console done");

        // Clock supply-low drives power-loss reset
        @(posedge SYS_CLK) cmd.clk_supply_low <= 1'b1;
        wait_sig(3, 1'b1, 8, n);
        note("plr assert", in_rng(n, 2, 5), 1);
        repeat (10) @(posedge SYS_CLK);
        cmd.clk_supply_low <= 1'b0;
        wait_sig(3, 1'b0, 40, n);
        note("plr release", in_rng(n, 20, 25), 1);
        repeat (SEQ) @(posedge SYS_CLK);
        clear_int();
        $display("test power loss done");

        // Received lines: restart-hold and console line-low trigger, reset inits
        for (int i = 1; i < 3; i++)
        begin
            @(posedge SYS_CLK) cmd.rx_low[i] <= 1'b1;
            wait_sig(0, 1'b1, 8, n);
            note("rx trigger", PF_INT, 1);
            clear_int();
            wait_sig(2, 1'b0, SEQ, n);
            repeat (5) @(posedge SYS_CLK);
            glitch <= 1'b1;
            @(posedge SYS_CLK) glitch <= 1'b0;
            repeat (30) @(posedge SYS_CLK);
            note("glitch kept", PF_INT, 0);
            cmd.rx_low[i] <= 1'b0;
            repeat (10) @(posedge SYS_CLK);
        end
        @(posedge SYS_CLK) cmd.rx_low[0] <= 1'b1;
        wait_sig(1, 1'b1, 8, n);
        note("plr rx init", MICROCODE_INITIALIZE, 1);
        @(posedge SYS_CLK) cmd.rx_low[0] <= 1'b0;
        repeat (SEQ) @(posedge SYS_CLK);
        clear_int();
        $display("test receivers done");

        // Maintenance strap cycles on its own
        @(posedge SYS_CLK) cmd.maint <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            wait_sig(0, 1'b1, SEQ, n);
            note("maint cycle", PF_INT, 1);
            clear_int();
            wait_sig(2, 1'b0, SEQ, n);
        end
        @(posedge SYS_CLK) cmd.maint <= 1'b0;
        repeat (SEQ) @(posedge SYS_CLK);
        note("drive level", DRIVE_LEVEL, 0);
        $display("test maintenance done");
        end_of_test();
    end
endmodule
